/* design/pqc_map.svh */
// register map, field positions, reset values and timing constants of the pulse counter
`ifndef PQC_MAP_SVH
`define PQC_MAP_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define PQC_OFS_CTRL      8'h00
`define PQC_OFS_STATUS    8'h08
`define PQC_OFS_CNT       8'h0C
`define PQC_OFS_TOP       8'h10
`define PQC_OFS_TOPB      8'h14
`define PQC_OFS_IF        8'h18
`define PQC_OFS_IFS       8'h1C
`define PQC_OFS_IFC       8'h20
`define PQC_OFS_IEN       8'h24
`define PQC_OFS_SYNCBUSY  8'h30

// ---------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------
`define PQC_CTRL_W        6
`define PQC_FLAG_W        3
`define PQC_FLAG_UF       0
`define PQC_FLAG_OF       1
`define PQC_FLAG_DC       2
`define PQC_CNT_W         8
`define PQC_TOP_RST       8'hFF
`define PQC_CNT_RST       8'h00
`define PQC_RESP_OKAY     2'b00
`define PQC_RESP_SLVERR   2'b10

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define PQC_SYS_HZ        40000000
`define PQC_LF_HZ         32000
`define PQC_LF_DIV        (`PQC_SYS_HZ / `PQC_LF_HZ)
`define PQC_LF_DIV_W      11
`define PQC_FILTER_ENABLE_LEN      3'd5
`define PQC_RST_EDGES     2

`endif

/* design/pqc_pkg.sv */
// types shared by the pulse counter design
package pqc_pkg;

	// ---------------------------------------------------------------
	// operating modes in mode field order
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		PQC_DISABLED,
		PQC_OVERSAMPLED_SINGLE_INPUT,
		PQC_PIN_CLOCKED_SINGLE_INPUT,
		PQC_PIN_CLOCKED_QUADRATURE
	} pqc_mode_t;

	// ---------------------------------------------------------------
	// control word, msb first
	// ---------------------------------------------------------------
	typedef struct packed {
		logic      domainResetEnable;
		logic      filterEnable;
		logic      edgeSelect;
		logic      countDirection;
		pqc_mode_t mode;
	} pqc_ctrl_t;

	// events raised by the counter domain in one cycle
	typedef struct packed {
		logic directionChange;
		logic overflow;
		logic underflow;
	} pqc_evt_t;

endpackage : pqc_pkg

/* design/pqc_pulse_counter_unit.sv */
// pulse counter with reload, quadrature decode and an AXI4-Lite register slave
// What this block does
// - writing a mode starts it, disabled code stops
// - mode codes: 0 off, 1 oversampled, 2 pin-single, 3 quadrature
// - oversampled mode counts selected edges of input A
// - single-input modes count up unless direction bit set
// - single-input modes never raise direction-change flag
// - pin-single counts input A rising edges, ignores B
// - optional filter needs 5 stable samples, oversampled only
// - polarity bit picks rising or falling edges in oversampled mode
// - polarity inverts quadrature direction, ignored in pin-single
// - quadrature samples B on both edges of A
// - A leading B means clockwise, direction set automatically
// - B fall counts dir 0, B rise dir 1
// - direction readable, change sets direction-change flag
// - down at zero: underflow flag, reload top
// - up at top: overflow flag, load zero
// - pin-clocked updates take 2 edges of pin A
// - domain-reset bit holds counter domain in reset
// - domain reset releases two domain clock edges later
// - low-frequency clock default, pin A clock otherwise
// - all flags share one interrupt line
// - no reflex event network inputs or outputs
`timescale 1ns/1ps
`include "pqc_map.svh"

module pqc_pulse_counter_unit (
	input  wire logic        sys_clk,
	input  wire logic        srst,
	input  wire logic        input_a_pin,
	input  wire logic        input_b_pin,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             shared_interrupt_line
);

	// ---------------------------------------------------------------
	// pin synchronisers and edge detection
	// ---------------------------------------------------------------
	logic aMeta_r, aSync_r, aDly_r, bMeta_r, bSync_r;
	always_ff @(posedge sys_clk)
	begin
		aMeta_r <= input_a_pin;
		aSync_r <= aMeta_r;
		aDly_r  <= aSync_r;
		bMeta_r <= input_b_pin;
		bSync_r <= bMeta_r;
	end
	wire logic aRise = aSync_r & ~aDly_r;
	wire logic aFall = ~aSync_r & aDly_r;

	// ---------------------------------------------------------------
	// low-frequency clock as an enable pulse
	// ---------------------------------------------------------------
	localparam logic [`PQC_LF_DIV_W-1:0] LF_LAST = `PQC_LF_DIV_W'(`PQC_LF_DIV - 1);
	logic [`PQC_LF_DIV_W-1:0] lfDiv_r;
	wire logic lfTick = (lfDiv_r == LF_LAST);
	always_ff @(posedge sys_clk)
	begin
		if (srst || lfTick)
			lfDiv_r <= '0;
		else
			lfDiv_r <= lfDiv_r + `PQC_LF_DIV_W'(1);
	end

	// ---------------------------------------------------------------
	// bus-side registers
	// ---------------------------------------------------------------
	pqc_pkg::pqc_ctrl_t      ctrl_r;
	logic [`PQC_CNT_W-1:0]   topValueBuffer_r;
	logic [`PQC_FLAG_W-1:0]  flags_r;
	logic [`PQC_FLAG_W-1:0]  ien_r;
	// domain clock follows the requested mode, so a new mode can still cross
	wire logic pinClocked = ctrl_r.mode[1];
	wire logic domTick    = pinClocked ? (aRise | aFall) : lfTick;

	// ---------------------------------------------------------------
	// counter domain reset
	// ---------------------------------------------------------------
	logic [1:0] rstPipe_r;
	wire logic domRst = ctrl_r.domainResetEnable | ~rstPipe_r[1];
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			rstPipe_r <= 2'b11;
		else if (ctrl_r.domainResetEnable)
			rstPipe_r <= 2'b00;
		else if (domTick)
			rstPipe_r <= {rstPipe_r[0], 1'b1};
	end

	// ---------------------------------------------------------------
	// two-stage transfer of software settings into the domain
	// ---------------------------------------------------------------
	pqc_pkg::pqc_ctrl_t    ctrlStage_r, domCtrl_r;
	logic [`PQC_CNT_W-1:0] topStage_r, topValue_r;
	always_ff @(posedge sys_clk)
	begin
		if (srst || domRst)
		begin
			ctrlStage_r <= '0;
			domCtrl_r   <= '0;
			topStage_r  <= `PQC_TOP_RST;
			topValue_r  <= `PQC_TOP_RST;
		end
		else if (domTick)
		begin
			ctrlStage_r <= ctrl_r;
			domCtrl_r   <= ctrlStage_r;
			topStage_r  <= topValueBuffer_r;
			topValue_r  <= topStage_r;
		end
	end
	wire logic ctrlBusy = (ctrl_r[`PQC_CTRL_W-2:0] != domCtrl_r[`PQC_CTRL_W-2:0]);
	wire logic topBusy  = (topValueBuffer_r != topValue_r);
	wire logic modeOvs  = (domCtrl_r.mode == pqc_pkg::PQC_OVERSAMPLED_SINGLE_INPUT);
	wire logic modePinS = (domCtrl_r.mode == pqc_pkg::PQC_PIN_CLOCKED_SINGLE_INPUT);
	wire logic modeQuad = (domCtrl_r.mode == pqc_pkg::PQC_PIN_CLOCKED_QUADRATURE);

	// ---------------------------------------------------------------
	// oversampled input path with pulse-width filter
	// ---------------------------------------------------------------
	logic       lastSamp_r, filtLvl_r, ovsLvl_r;
	logic [2:0] stable_r;
	wire logic       sameSamp  = (aSync_r == lastSamp_r);
	wire logic [2:0] stableNxt = !sameSamp ? 3'd1 :
		(stable_r == `PQC_FILTER_ENABLE_LEN) ? stable_r : stable_r + 3'd1;
	wire logic filtNxt = (stableNxt == `PQC_FILTER_ENABLE_LEN) ? aSync_r : filtLvl_r;
	wire logic ovsNxt  = domCtrl_r.filterEnable ? filtNxt : aSync_r;
	wire logic ovsStep = modeOvs & lfTick;
	wire logic ovsEdge = ovsStep & (domCtrl_r.edgeSelect ? (ovsLvl_r & ~ovsNxt)
		: (~ovsLvl_r & ovsNxt));
	always_ff @(posedge sys_clk)
	begin
		if (srst || domRst || !modeOvs)
		begin
			lastSamp_r <= 1'b0;
			filtLvl_r  <= 1'b0;
			ovsLvl_r   <= 1'b0;
			stable_r   <= 3'd0;
		end
		else if (lfTick)
		begin
			lastSamp_r <= aSync_r;
			filtLvl_r  <= filtNxt;
			ovsLvl_r   <= ovsNxt;
			stable_r   <= stableNxt;
		end
	end

	// ---------------------------------------------------------------
	// quadrature decode: B sampled at every edge of A
	// ---------------------------------------------------------------
	logic bPrev_r, quadDir_r;
	wire logic quadStep = modeQuad & (aRise | aFall);
	wire logic bPos     = bSync_r & ~bPrev_r;
	wire logic bNeg     = ~bSync_r & bPrev_r;
	wire logic quadEn   = quadStep & (bPos ^ bNeg);
	wire logic quadDirRaw = bPos & ~bNeg;
	wire logic quadDir    = quadDirRaw ^ domCtrl_r.edgeSelect;
	always_ff @(posedge sys_clk)
	begin
		if (srst || domRst)
		begin
			bPrev_r   <= 1'b0;
			quadDir_r <= 1'b0;
		end
		else if (quadStep)
		begin
			bPrev_r <= bSync_r;
			if (quadEn)
				quadDir_r <= quadDir;
		end
	end

	// ---------------------------------------------------------------
	// counter with reload
	// ---------------------------------------------------------------
	wire logic pinSEn = modePinS & aRise;
	wire logic cntEn  = ovsEdge | pinSEn | quadEn;
	wire logic cntDown = modeQuad ? quadDir : domCtrl_r.countDirection;
	logic [`PQC_CNT_W-1:0] counterValue_r;
	wire logic atZero = (counterValue_r == `PQC_CNT_RST);
	wire logic atTop  = (counterValue_r == topValue_r);
	pqc_pkg::pqc_evt_t evt;
	assign evt.underflow       = cntEn & cntDown & atZero;
	assign evt.overflow        = cntEn & ~cntDown & atTop;
	assign evt.directionChange = quadEn & (quadDir != quadDir_r);
	always_ff @(posedge sys_clk)
	begin
		if (srst || domRst)
			counterValue_r <= `PQC_CNT_RST;
		else if (evt.underflow)
			counterValue_r <= topValue_r;
		else if (evt.overflow)
			counterValue_r <= `PQC_CNT_RST;
		else if (cntEn)
			counterValue_r <= cntDown ? counterValue_r - 8'h01 : counterValue_r + 8'h01;
	end

	// ---------------------------------------------------------------
	// AXI4-Lite write channel
	// ---------------------------------------------------------------
	logic        awHave_r, wHave_r;
	logic [7:0]  awAddr_r;
	logic [31:0] wData_r;
	logic [3:0]  wStrb_r;
	wire logic wrGo   = awHave_r & wHave_r & ~s_axi_bvalid;
	wire logic lane0  = wStrb_r[0];
	wire logic wrCtrl = wrGo & lane0 & (awAddr_r == `PQC_OFS_CTRL);
	wire logic wrTopB = wrGo & lane0 & (awAddr_r == `PQC_OFS_TOPB);
	wire logic wrIfs  = wrGo & lane0 & (awAddr_r == `PQC_OFS_IFS);
	wire logic wrIfc  = wrGo & lane0 & (awAddr_r == `PQC_OFS_IFC);
	wire logic wrIen  = wrGo & lane0 & (awAddr_r == `PQC_OFS_IEN);
	wire logic wrMapped = (awAddr_r == `PQC_OFS_CTRL) || (awAddr_r == `PQC_OFS_STATUS)
		|| (awAddr_r == `PQC_OFS_CNT) || (awAddr_r == `PQC_OFS_TOP)
		|| (awAddr_r == `PQC_OFS_TOPB) || (awAddr_r == `PQC_OFS_IF)
		|| (awAddr_r == `PQC_OFS_IFS) || (awAddr_r == `PQC_OFS_IFC)
		|| (awAddr_r == `PQC_OFS_IEN) || (awAddr_r == `PQC_OFS_SYNCBUSY);
	wire logic [1:0] wrResp = wrMapped ? `PQC_RESP_OKAY : `PQC_RESP_SLVERR;
	wire logic awTake = s_axi_awvalid & s_axi_awready;
	wire logic wTake  = s_axi_wvalid & s_axi_wready;
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			awHave_r      <= 1'b0;
			wHave_r       <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `PQC_RESP_OKAY;
		end
		else
		begin
			s_axi_awready <= s_axi_awvalid & ~s_axi_awready & ~awHave_r & ~s_axi_bvalid;
			s_axi_wready  <= s_axi_wvalid & ~s_axi_wready & ~wHave_r & ~s_axi_bvalid;
			if (awTake)
			begin
				awHave_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
			end
			if (wTake)
			begin
				wHave_r <= 1'b1;
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
			end
			if (wrGo)
			begin
				awHave_r     <= 1'b0;
				wHave_r      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wrResp;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// software registers, flags and interrupt
	// ---------------------------------------------------------------
	wire logic [`PQC_FLAG_W-1:0] wrFlagBits = wData_r[`PQC_FLAG_W-1:0];
	wire logic [`PQC_FLAG_W-1:0] flagSet    = {`PQC_FLAG_W{wrIfs}} & wrFlagBits;
	wire logic [`PQC_FLAG_W-1:0] flagClr    = {`PQC_FLAG_W{wrIfc}} & wrFlagBits;
	// a hardware event in the clearing cycle survives the clear
	wire logic [`PQC_FLAG_W-1:0] flags_nxt  = (flags_r & ~flagClr) | flagSet | evt;
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			ctrl_r                <= '0;
			topValueBuffer_r      <= `PQC_TOP_RST;
			flags_r               <= '0;
			ien_r                 <= '0;
			shared_interrupt_line <= 1'b0;
		end
		else
		begin
			if (wrCtrl)
				ctrl_r <= pqc_pkg::pqc_ctrl_t'(wData_r[`PQC_CTRL_W-1:0]);
			if (wrTopB)
				topValueBuffer_r <= wData_r[`PQC_CNT_W-1:0];
			if (wrIen)
				ien_r <= wrFlagBits;
			flags_r               <= flags_nxt;
			shared_interrupt_line <= |(flags_nxt & (wrIen ? wrFlagBits : ien_r));
		end
	end

	// ---------------------------------------------------------------
	// AXI4-Lite read channel
	// ---------------------------------------------------------------
	logic [31:0] rdMux;
	logic        rdMapped;
	always_comb
	begin
		rdMux    = 32'h00000000;
		rdMapped = 1'b1;
		if (s_axi_araddr == `PQC_OFS_CTRL)
			rdMux[`PQC_CTRL_W-1:0] = ctrl_r;
		else if (s_axi_araddr == `PQC_OFS_STATUS)
			rdMux[0] = quadDir_r;
		else if (s_axi_araddr == `PQC_OFS_CNT)
			rdMux[`PQC_CNT_W-1:0] = counterValue_r;
		else if (s_axi_araddr == `PQC_OFS_TOP)
			rdMux[`PQC_CNT_W-1:0] = topValue_r;
		else if (s_axi_araddr == `PQC_OFS_TOPB)
			rdMux[`PQC_CNT_W-1:0] = topValueBuffer_r;
		else if (s_axi_araddr == `PQC_OFS_IF)
			rdMux[`PQC_FLAG_W-1:0] = flags_r;
		else if (s_axi_araddr == `PQC_OFS_IEN)
			rdMux[`PQC_FLAG_W-1:0] = ien_r;
		else if (s_axi_araddr == `PQC_OFS_SYNCBUSY)
			rdMux[1:0] = {topBusy, ctrlBusy};
		else if ((s_axi_araddr != `PQC_OFS_IFS) && (s_axi_araddr != `PQC_OFS_IFC))
			rdMapped = 1'b0;
	end
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `PQC_RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rdMux;
				s_axi_rresp  <= rdMapped ? `PQC_RESP_OKAY : `PQC_RESP_SLVERR;
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	AST_OFF_NO_COUNT: assert property (
		(domCtrl_r.mode == pqc_pkg::PQC_DISABLED) |=> $stable(counterValue_r) || $past(domRst))
		else $error("counter moved while disabled");
	AST_UF_RELOAD: assert property (
		(cntEn && cntDown && atZero && !domRst) |=>
			(counterValue_r == $past(topValue_r)) && flags_r[`PQC_FLAG_UF])
		else $error("underflow did not reload top or set flag");
	AST_OF_ZERO: assert property (
		(cntEn && !cntDown && atTop && !domRst) |=>
			(counterValue_r == `PQC_CNT_RST) && flags_r[`PQC_FLAG_OF])
		else $error("overflow did not clear counter or set flag");
	AST_NO_DC_SINGLE: assert property (
		((modeOvs || modePinS) && !wrIfs) |=> !$rose(flags_r[`PQC_FLAG_DC]))
		else $error("direction change raised outside quadrature");
	AST_PINS_RISE_ONLY: assert property (
		(modePinS && !domRst && !aRise) |=> $stable(counterValue_r))
		else $error("pin-single counted without rising A");
	AST_QUAD_A_EDGE: assert property (
		(modeQuad && !domRst && !aRise && !aFall) |=> $stable(counterValue_r))
		else $error("quadrature counted without an A edge");
	AST_DOM_RESET_HOLD: assert property (
		ctrl_r.domainResetEnable |=> (counterValue_r == `PQC_CNT_RST)
			&& (topValue_r == `PQC_TOP_RST))
		else $error("domain reset did not restore values");
	AST_IRQ_LEVEL: assert property (
		##1 shared_interrupt_line == |(flags_r & ien_r))
		else $error("interrupt line disagrees with enabled flags");
	AST_FILTER_HOLD: assert property (
		(modeOvs && domCtrl_r.filterEnable && lfTick && !domRst && (aSync_r != lastSamp_r))
			|=> (filtLvl_r == $past(filtLvl_r)))
		else $error("filter passed a level held under five samples");
endmodule : pqc_pulse_counter_unit

/* sim/pqc_encoder_model.sv */
// behavioural pulse source and quadrature encoder for the two count pins
`timescale 1ns/1ps

// ---------------------------------------------------------------
// kind 0: a toggles, b steady; 1: a toggles, b wanders; 2: b flips once first
// ---------------------------------------------------------------
module pqc_encoder_model (
	input  wire logic        go,
	input  wire logic [1:0]  kind,
	input  wire logic [7:0]  edges,
	input  wire logic [31:0] halfNs,
	output logic             pinA,
	output logic             pinB,
	output logic             busy
);
	initial
	begin
		pinA = 1'b0;
		pinB = 1'b0;
		busy = 1'b0;
	end

	// a stands still between bursts, as a sensor with no motion would
	always @(posedge go)
	begin
		busy = 1'b1;
		if (kind == 2'd2)
			pinB = ~pinB;
		repeat (edges)
		begin
			#(halfNs / 2);
			if (kind == 2'd1)
				pinB = ~pinB;
			#(halfNs - halfNs / 2);
			pinA = ~pinA;
		end
		if (kind == 2'd1)
			pinB = 1'b0;
		busy = 1'b0;
	end
endmodule : pqc_encoder_model

/* sim/pqc_pulse_quadrature_counter_tb_top.sv */
// self-checking bench of the pulse counter: bus, pin modes, flags and interrupt
`timescale 1ns/1ps
`include "pqc_map.svh"

module pqc_pulse_quadrature_counter_tb_top;
	logic        sysClk   = 1'b0;
	logic        srst     = 1'b1;
	logic [7:0]  awAddr   = 8'h00;
	logic        awValid  = 1'b0;
	logic        awReady;
	logic [31:0] wData    = 32'h0;
	logic        wValid   = 1'b0;
	logic [3:0]  wStrb    = 4'hF;
	logic        wReady;
	logic [1:0]  bResp;
	logic        bValid;
	logic        bReady   = 1'b0;
	logic [7:0]  arAddr   = 8'h00;
	logic        arValid  = 1'b0;
	logic        arReady;
	logic [31:0] rData;
	logic [1:0]  rResp;
	logic        rValid;
	logic        rReady   = 1'b0;
	logic        irqLine;
	logic        pinA;
	logic        pinB;
	logic        go       = 1'b0;
	logic [1:0]  kind     = 2'd0;
	logic [7:0]  edges    = 8'd0;
	logic [31:0] halfNs   = 32'd100;
	logic        busy;
	logic [31:0] rndState = 32'hD20D;
	int          err_count = 0;
	int          checked   = 0;

	pqc_pulse_counter_unit pqc_pulse_counter_unit_i (
		.sys_clk(sysClk), .srst(srst), .input_a_pin(pinA), .input_b_pin(pinB),
		.s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
		.s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
		.s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
		.s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
		.s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
		.s_axi_rvalid(rValid), .s_axi_rready(rReady), .shared_interrupt_line(irqLine)
	);

	pqc_encoder_model pqc_encoder_model_i (
		.go(go), .kind(kind), .edges(edges), .halfNs(halfNs),
		.pinA(pinA), .pinB(pinB), .busy(busy)
	);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] rnd();
		rndState ^= rndState << 13;
		rndState ^= rndState >> 17;
		rndState ^= rndState << 5;
		return rndState;
	endfunction : rnd

	function automatic logic [31:0] expCnt(input int n, input int t, input logic down);
		int v;
		v = 0;
		for (int i = 0; i < n; i++)
			v = down ? ((v == 0) ? t : v - 1) : ((v == t) ? 0 : v + 1);
		return 32'(v);
	endfunction : expCnt

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic final_report;
		$display("counts: checked %0d, mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report

	// address and data are offered together, each released once taken
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
		@(posedge sysClk);
		awAddr  <= a;
		awValid <= 1'b1;
		wData   <= d;
		wValid  <= 1'b1;
		bReady  <= 1'b1;
		do
		begin
			@(posedge sysClk);
			if (awReady)
				awValid <= 1'b0;
			if (wReady)
				wValid <= 1'b0;
		end
		while (bValid !== 1'b1);
		bReady <= 1'b0;
		chk("write answer", {30'h0, bResp}, 32'h0);
	endtask : axiWrite

	task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge sysClk);
		arAddr  <= a;
		arValid <= 1'b1;
		rReady  <= 1'b1;
		do
		begin
			@(posedge sysClk);
			if (arReady)
				arValid <= 1'b0;
		end
		while (rValid !== 1'b1);
		d = rData;
		r = rResp;
		rReady <= 1'b0;
	endtask : axiRead

	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string name);
		logic [31:0] d;
		logic [1:0]  r;
		axiRead(a, d, r);
		chk(name, d, exp);
	endtask : rdChk

	task automatic run(input logic [1:0] kd, input logic [7:0] n, input logic [31:0] h);
		@(posedge sysClk);
		kind   <= kd;
		edges  <= n;
		halfNs <= h;
		go     <= 1'b1;
		@(posedge sysClk);
		go <= 1'b0;
		while (busy !== 1'b0)
			@(posedge sysClk);
		repeat (20) @(posedge sysClk);
	endtask : run

	// domain reset in quadrature mode: edges with b steady are never counted
	task automatic restart(input logic [7:0] t);
		axiWrite(`PQC_OFS_CTRL, 32'h23);
		rdChk(`PQC_OFS_CNT, 32'h0, "count in reset");
		rdChk(`PQC_OFS_TOP, 32'hFF, "top in reset");
		axiWrite(`PQC_OFS_TOPB, {24'h0, t});
		axiWrite(`PQC_OFS_CTRL, 32'h03);
		run(2'd0, 8'd4, 32'd100);
		rdChk(`PQC_OFS_TOP, {24'h0, t}, "top loaded");
		axiWrite(`PQC_OFS_IFC, 32'h7);
	endtask : restart

	// ---------------------------------------------------------------
	// clock, watchdog and main sequence
	// ---------------------------------------------------------------
	initial
	begin
		forever #12.5 sysClk = ~sysClk;
	end

	initial
	begin
		repeat (90000) @(posedge sysClk);
		err_count++;
		final_report();
	end

	initial
	begin
		logic [7:0]  regA [6] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
		logic [31:0] regE [6] = '{32'h0, 32'h0, 32'h0, 32'hFF, 32'hFF, 32'h0};
		logic [31:0] d;
		logic [1:0]  r;
		logic        e;
		int          t;
		int          n;
		repeat (10) @(posedge sysClk);
		srst <= 1'b0;
		for (int i = 0; i < 6; i++)
			rdChk(regA[i], regE[i], "reset value");
		axiRead(8'h40, d, r);
		chk("unmapped answer", {30'h0, r}, 32'h2);
		axiWrite(`PQC_OFS_CNT, 32'h55);
		rdChk(`PQC_OFS_CNT, 32'h0, "read-only count");
		wStrb <= 4'h0;
		axiWrite(`PQC_OFS_TOPB, 32'h12);
		wStrb <= 4'hF;
		rdChk(`PQC_OFS_TOPB, 32'hFF, "masked write");
		$display("test registers done");
		for (int i = 0; i < 4; i++)
		begin
			t = 3 + int'(rnd() % 8);
			n = 1 + int'(rnd() % 24);
			d = rnd();
			e = d[0];
			restart(8'(t));
			axiWrite(`PQC_OFS_CTRL, {28'h0, e, i[0], 2'b10});
			run(2'd0, 8'd2, 32'd100);
			rdChk(`PQC_OFS_SYNCBUSY, 32'h0, "sync busy");
			run(2'd1, 8'(2 * n), 32'd100);
			rdChk(`PQC_OFS_CNT, expCnt(n, t, i[0]), "pin count");
			d = i[0] ? 32'h1 : ((n > t) ? 32'h2 : 32'h0);
			rdChk(`PQC_OFS_IF, d, "pin flags");
			axiWrite(`PQC_OFS_IEN, 32'h3);
			repeat (2) @(posedge sysClk);
			chk("flag irq", {31'h0, irqLine}, {31'h0, d != 0});
		end
		axiWrite(`PQC_OFS_IEN, 32'h0);
		axiWrite(`PQC_OFS_IFS, 32'h1);
		repeat (2) @(posedge sysClk);
		chk("masked irq", {31'h0, irqLine}, 32'h0);
		rdChk(`PQC_OFS_IF, 32'h1, "set flag");
		axiWrite(`PQC_OFS_IEN, 32'h1);
		repeat (2) @(posedge sysClk);
		chk("enabled irq", {31'h0, irqLine}, 32'h1);
		axiWrite(`PQC_OFS_IFC, 32'h1);
		repeat (2) @(posedge sysClk);
		chk("cleared irq", {31'h0, irqLine}, 32'h0);
		$display("test single input done");
		for (int i = 0; i < 2; i++)
		begin
			restart(8'd5);
			axiWrite(`PQC_OFS_CTRL, {28'h0, i[0], 3'b011});
			run(2'd0, 8'd2, 32'd100);
			run(2'd2, 8'd2, 32'd100);
			if (i == 0)
				rdChk(`PQC_OFS_STATUS, 32'h1, "direction");
			run(2'd2, 8'd2, 32'd100);
			rdChk(`PQC_OFS_CNT, 32'h0, "quad count");
			rdChk(`PQC_OFS_IF, i ? 32'h4 : 32'h7, "quad flags");
		end
		$display("test quadrature done");
		axiWrite(`PQC_OFS_CTRL, 32'h39);
		axiWrite(`PQC_OFS_CTRL, 32'h19);
		repeat (5000) @(posedge sysClk);
		run(2'd0, 8'd2, 32'd62500);
		run(2'd1, 8'd4, 32'd218750);
		repeat (10000) @(posedge sysClk);
		rdChk(`PQC_OFS_CNT, 32'h2, "oversampled count");
		axiWrite(`PQC_OFS_CTRL, 32'h0);
		repeat (4000) @(posedge sysClk);
		run(2'd1, 8'd6, 32'd100);
		rdChk(`PQC_OFS_CNT, 32'h2, "disabled count");
		$display("test oversampled done");
		final_report();
	end
endmodule : pqc_pulse_quadrature_counter_tb_top
